// File: logic/scpm_pkg.sv
// Shared constants for the smart card power-management configuration registers.
// Assumes byte addresses of configuration space; registers live in aligned dwords.
package scpm_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_POWER_CTRL_STATUS    = 8'h48;
  localparam logic [7:0] OFF_BRIDGE_EXT_BYTE      = 8'h4a;
  localparam logic [7:0] OFF_POWER_DATA_BYTE      = 8'h4b;
  localparam logic [7:0] OFF_GENERAL_CONTROL      = 8'h4c;
  localparam logic [7:0] OFF_BOARD_IDENTITY_ALIAS = 8'h50;
  localparam logic [7:0] OFF_BOARD_MAKER_CODE     = 8'h2c;
  localparam logic [7:0] OFF_BOARD_PRODUCT_CODE   = 8'h2e;

  // Power control/status fields
  localparam int PCS_FLAG_BIT  = 15;
  localparam int PCS_ALLOW_BIT = 8;
  localparam int PCS_LEVEL_LO  = 0;

  // General control fields
  localparam int GC_INT_SEL_LO = 5;
  localparam int GC_COLD_BIT   = 4;

  // Power levels
  localparam logic [1:0] LEVEL_D0     = 2'h0;
  localparam logic [1:0] LEVEL_D3_HOT = 2'h3;

  // Reset values
  localparam logic [15:0] RST_POWER_CTRL_STATUS    = 16'h0000;
  localparam logic [7:0]  RST_BRIDGE_EXT_BYTE      = 8'h00;
  localparam logic [7:0]  RST_POWER_DATA_BYTE      = 8'h00;
  localparam logic [7:0]  RST_GENERAL_CONTROL      = 8'h00;
  localparam logic [31:0] RST_BOARD_IDENTITY_ALIAS = 32'h00000000;

  // Standby current codes
  localparam logic [2:0] STANDBY_SELF_POWERED = 3'h0;
  localparam logic [2:0] STANDBY_AUX_NEEDED   = 3'h1;

  // Length of the internal function reset after leaving hot D3
  localparam int FUNC_RESET_CYCLES = 4;

endpackage : scpm_pkg

// File: logic/scpm_irq_route.sv
// Interrupt pin choice and routing of the function interrupt.
// Assumes override pins and the function interrupt are synchronous to mclk_i.
`timescale 1ns/1ps
module scpm_irq_route
(
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       reset_n_i,
  // Choice
  input  wire logic [1:0] int_sel_i,
  input  wire logic [3:0] irq_override_pins_i,
  input  wire logic       func_irq_i,
  // Results
  output logic      [7:0] reported_irq_pin_o,
  output logic      [3:0] irq_line_o
);

  typedef struct packed {
    logic [7:0] pin;
    logic [3:0] line;
  } scpm_route_s;

  scpm_route_s st;
  scpm_route_s next_st;
  logic [1:0]  pick;

  always_comb
  begin
    pick = int_sel_i;
    // Override pins win; the lowest asserted one names the line
    if (irq_override_pins_i != 4'h0)
    begin
      pick = irq_override_pins_i[0] ? 2'h0 :
             irq_override_pins_i[1] ? 2'h1 :
             irq_override_pins_i[2] ? 2'h2 : 2'h3;
    end
    next_st.pin  = {6'h00, pick} + 8'h01;
    next_st.line = func_irq_i ? (4'h1 << pick) : 4'h0;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign reported_irq_pin_o = st.pin;
  assign irq_line_o         = st.line;

endmodule : scpm_irq_route

// File: logic/scpm_func_reset.sv
// Internal function reset raised when the power level leaves hot D3 for D0.
// Assumes the level input is the registered power level field.
`timescale 1ns/1ps
module scpm_func_reset
#(
  parameter int RESET_CYCLES = scpm_pkg::FUNC_RESET_CYCLES
)
(
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       reset_n_i,
  // Power level
  input  wire logic [1:0] level_i,
  // Internal reset out
  output logic            func_reset_o
);

  typedef struct packed {
    logic [1:0] prev;
    logic [7:0] cnt;
    logic       active;
  } scpm_fr_s;

  scpm_fr_s st;
  scpm_fr_s next_st;

  always_comb
  begin
    next_st      = st;
    next_st.prev = level_i;
    if (st.prev == scpm_pkg::LEVEL_D3_HOT && level_i == scpm_pkg::LEVEL_D0)
    begin
      next_st.active = 1'b1;
      next_st.cnt    = 8'(RESET_CYCLES - 1);
    end
    else if (st.active)
    begin
      if (st.cnt == 8'h00)
        next_st.active = 1'b0;
      else
        next_st.cnt = st.cnt - 8'h01;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign func_reset_o = st.active;

endmodule : scpm_func_reset

// File: logic/scpm_regs.sv
// Power-management configuration registers of the smart card function.
// Assumes configuration cycles arrive as one-cycle requests on mclk_i;
// reset_n_i is the global reset pin, the only reset that clears these fields.
//
// How it works
// - Internal function reset leaves control/status intact
// - Wake flag is bit 15, resets zero
// - Data scale and select fields read zero
// - Bit 8 enables wake signalling, else none
// - Bits 1-0 hold power level D0..D3hot
// - Control/status bits 7-2 read zero
// - Sticky fields cleared only by global reset
// - Extension and data bytes read zero
// - Control bits 6-5 choose interrupt pin
// - Override pins make the choice ignored
// - Control bit 4 mirrors cold wake capability
// - Control bit 7 and 3-0 read zero
// - 32-bit alias at 50h mirrored at 2Ch/2Eh
// - Alias bits 31-16 show at 2Eh
// - Alias bits 15-0 show at 2Ch
// - Standby current 000b or 001b by capability
`timescale 1ns/1ps
module scpm_regs
#(
  parameter int RESET_CYCLES = scpm_pkg::FUNC_RESET_CYCLES
)
(
  // Clock and global reset
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  // Configuration cycles
  input  wire logic        cfg_valid_i,
  input  wire logic        cfg_write_i,
  input  wire logic [7:0]  cfg_addr_i,
  input  wire logic [3:0]  cfg_be_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic      [31:0] cfg_rdata_o,
  output logic             cfg_ack_o,
  // Function events and pins
  input  wire logic        wake_event_i,
  input  wire logic        func_irq_i,
  input  wire logic [3:0]  irq_override_pins_i,
  // Wake and interrupt outputs
  output logic             pme_o,
  output logic      [3:0]  irq_line_o,
  output logic      [7:0]  reported_irq_pin_o,
  // Capability reflection, power level and internal reset
  output logic             cold_wake_capable_flag_o,
  output logic      [2:0]  standby_current_o,
  output logic      [1:0]  power_level_field_o,
  output logic             func_reset_o
);

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic        wake_event_flag;
    logic        wake_signal_allow;
    logic [1:0]  power_level_field;
    logic [1:0]  int_sel;
    logic        cold_state_wake_cap;
    logic [31:0] board_identity_alias;
    logic [31:0] rdata;
    logic        ack;
    logic        pme;
    logic        cap_flag;
    logic [2:0]  standby;
  } scpm_main_s;

  scpm_main_s st;
  scpm_main_s next_st;

  function automatic logic [5:0] dw(input logic [7:0] a);
    dw = a[7:2];
  endfunction : dw

  logic wr;
  logic hit_pcs;
  logic hit_gc;
  logic hit_alias;
  logic hit_ids;

  assign wr        = cfg_valid_i && cfg_write_i;
  assign hit_pcs   = dw(cfg_addr_i) == dw(scpm_pkg::OFF_POWER_CTRL_STATUS);
  assign hit_gc    = dw(cfg_addr_i) == dw(scpm_pkg::OFF_GENERAL_CONTROL);
  assign hit_alias = dw(cfg_addr_i) == dw(scpm_pkg::OFF_BOARD_IDENTITY_ALIAS);
  assign hit_ids   = dw(cfg_addr_i) == dw(scpm_pkg::OFF_BOARD_MAKER_CODE);

  ////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    next_st     = st;
    next_st.ack = cfg_valid_i;
    // Power control/status, byte lanes 0 and 1
    if (wr && hit_pcs && cfg_be_i[0])
      next_st.power_level_field = cfg_wdata_i[scpm_pkg::PCS_LEVEL_LO +: 2];
    if (wr && hit_pcs && cfg_be_i[1])
    begin
      next_st.wake_signal_allow = cfg_wdata_i[scpm_pkg::PCS_ALLOW_BIT];
      if (cfg_wdata_i[scpm_pkg::PCS_FLAG_BIT])
        next_st.wake_event_flag = 1'b0;
    end
    // A wake event in the clearing cycle is kept
    if (wake_event_i)
      next_st.wake_event_flag = 1'b1;
    if (wr && hit_gc && cfg_be_i[0])
    begin
      next_st.int_sel             = cfg_wdata_i[scpm_pkg::GC_INT_SEL_LO +: 2];
      next_st.cold_state_wake_cap = cfg_wdata_i[scpm_pkg::GC_COLD_BIT];
    end
    for (int b = 0; b < 4; b++)
    begin
      if (wr && hit_alias && cfg_be_i[b])
        next_st.board_identity_alias[8*b +: 8] = cfg_wdata_i[8*b +: 8];
    end
    // Read data; unmapped dwords read zero
    next_st.rdata = 32'h00000000;
    if (cfg_valid_i && !cfg_write_i)
    begin
      if (hit_pcs)
        next_st.rdata = {scpm_pkg::RST_POWER_DATA_BYTE,
                         scpm_pkg::RST_BRIDGE_EXT_BYTE,
                         st.wake_event_flag, 6'h00,
                         st.wake_signal_allow, 6'h00,
                         st.power_level_field};
      else if (hit_gc)
        next_st.rdata = {24'h000000, 1'b0, st.int_sel,
                         st.cold_state_wake_cap, 4'h0};
      else if (hit_alias)
        next_st.rdata = st.board_identity_alias;
      else if (hit_ids)
        next_st.rdata = st.board_identity_alias;
    end
    // Registered so the wake pin never glitches on a config write
    next_st.pme      = st.wake_event_flag && st.wake_signal_allow;
    next_st.cap_flag = st.cold_state_wake_cap;
    next_st.standby  = st.cold_state_wake_cap ? scpm_pkg::STANDBY_AUX_NEEDED
                                              : scpm_pkg::STANDBY_SELF_POWERED;
  end

  // Only the global reset touches this state; the function reset does not
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      st                      <= '0;
      st.power_level_field    <= scpm_pkg::RST_POWER_CTRL_STATUS[1:0];
      st.board_identity_alias <= scpm_pkg::RST_BOARD_IDENTITY_ALIAS;
    end
    else
      st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////

  scpm_irq_route u_route
  (
    .mclk_i              (mclk_i),
    .reset_n_i           (reset_n_i),
    .int_sel_i           (st.int_sel),
    .irq_override_pins_i (irq_override_pins_i),
    .func_irq_i          (func_irq_i),
    .reported_irq_pin_o  (reported_irq_pin_o),
    .irq_line_o          (irq_line_o)
  );

  scpm_func_reset #(.RESET_CYCLES(RESET_CYCLES)) u_freset
  (
    .mclk_i       (mclk_i),
    .reset_n_i    (reset_n_i),
    .level_i      (st.power_level_field),
    .func_reset_o (func_reset_o)
  );

  assign cfg_rdata_o              = st.rdata;
  assign cfg_ack_o                = st.ack;
  assign pme_o                    = st.pme;
  assign cold_wake_capable_flag_o = st.cap_flag;
  assign standby_current_o        = st.standby;
  assign power_level_field_o      = st.power_level_field;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_pcs_read;
    cfg_valid_i && !cfg_write_i && hit_pcs;
  endsequence

  sequence s_alias_write_all;
    wr && hit_alias && cfg_be_i == 4'hf;
  endsequence

  sequence s_gc_read;
    cfg_valid_i && !cfg_write_i && hit_gc;
  endsequence

  sequence s_ids_read;
    cfg_valid_i && !cfg_write_i && hit_ids;
  endsequence

  // Leaving hot D3 straight for D0 is the only path that starts the function reset
  sequence s_leave_d3;
    st.power_level_field == scpm_pkg::LEVEL_D3_HOT ##1
      st.power_level_field == scpm_pkg::LEVEL_D0;
  endsequence

  property p_flag_set;
    wake_event_i |=> st.wake_event_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("wake flag not set");

  property p_clear_one;
    wr && hit_pcs && cfg_be_i[1] && cfg_wdata_i[15] && !wake_event_i
      |=> !st.wake_event_flag;
  endproperty
  a_clear_one: assert property (p_clear_one) else $error("flag not cleared");

  property p_keep_zero;
    !(wr && hit_pcs && cfg_be_i[1] && cfg_wdata_i[15]) |=> !$fell(st.wake_event_flag);
  endproperty
  a_keep_zero: assert property (p_keep_zero) else $error("flag lost");

  property p_pme;
    pme_o |-> $past(st.wake_event_flag) && $past(st.wake_signal_allow);
  endproperty
  a_pme: assert property (p_pme) else $error("wake output without cause");

  property p_pcs_zero;
    s_pcs_read |=> cfg_ack_o && cfg_rdata_o[31:16] == 16'h0000 &&
      cfg_rdata_o[14:9] == 6'h00 && cfg_rdata_o[7:2] == 6'h00;
  endproperty
  a_pcs_zero: assert property (p_pcs_zero) else $error("zero fields nonzero");

  property p_level_write;
    wr && hit_pcs && cfg_be_i[0] |=> power_level_field_o == $past(cfg_wdata_i[1:0]);
  endproperty
  a_level_write: assert property (p_level_write) else $error("level not written");

  property p_level_kept;
    func_reset_o && !(wr && hit_pcs) |=> $stable(power_level_field_o);
  endproperty
  a_level_kept: assert property (p_level_kept) else $error("level lost");

  property p_alias_mirror;
    s_alias_write_all ##1 (!cfg_valid_i) [*2] ##1 s_ids_read
      |=> cfg_rdata_o == $past(cfg_wdata_i, 4);
  endproperty
  a_alias_mirror: assert property (p_alias_mirror) else $error("alias not mirrored");

  property p_standby;
    ##2 1 |-> standby_current_o == ($past(st.cold_state_wake_cap)
      ? scpm_pkg::STANDBY_AUX_NEEDED : scpm_pkg::STANDBY_SELF_POWERED);
  endproperty
  a_standby: assert property (p_standby) else $error("standby code wrong");

  property p_ids_read;
    s_ids_read |=> cfg_rdata_o == $past(st.board_identity_alias);
  endproperty
  a_ids_read: assert property (p_ids_read) else $error("id dword not alias");

  property p_alias_lane;
    wr && hit_alias && cfg_be_i[0]
      |=> st.board_identity_alias[7:0] == $past(cfg_wdata_i[7:0]);
  endproperty
  a_alias_lane: assert property (p_alias_lane) else $error("alias lane lost");

  property p_gc_zero;
    s_gc_read |=> cfg_ack_o && cfg_rdata_o[31:7] == 25'h0000000 &&
      cfg_rdata_o[3:0] == 4'h0;
  endproperty
  a_gc_zero: assert property (p_gc_zero) else $error("control zero bits set");

  property p_bytes_zero;
    s_pcs_read |=> cfg_rdata_o[31:16] ==
      {scpm_pkg::RST_POWER_DATA_BYTE, scpm_pkg::RST_BRIDGE_EXT_BYTE};
  endproperty
  a_bytes_zero: assert property (p_bytes_zero) else $error("ext bytes nonzero");

  property p_rsvd_zero;
    s_pcs_read |=> cfg_rdata_o[7:2] == 6'h00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");

  property p_allow_off;
    !st.wake_signal_allow |=> !pme_o;
  endproperty
  a_allow_off: assert property (p_allow_off) else $error("wake while disabled");

  property p_int_sel;
    wr && hit_gc && cfg_be_i[0] |=> st.int_sel == $past(cfg_wdata_i[6:5]);
  endproperty
  a_int_sel: assert property (p_int_sel) else $error("pin choice not written");

  property p_cold_mirror;
    ##1 1 |-> cold_wake_capable_flag_o == $past(st.cold_state_wake_cap);
  endproperty
  a_cold_mirror: assert property (p_cold_mirror) else $error("cap flag wrong");

  property p_override;
    irq_override_pins_i[2] && irq_override_pins_i[1:0] == 2'h0
      |=> reported_irq_pin_o == 8'h03;
  endproperty
  a_override: assert property (p_override) else $error("override ignored");

  property p_func_reset;
    s_leave_d3 |=> func_reset_o;
  endproperty
  a_func_reset: assert property (p_func_reset) else $error("no function reset");

  property p_flag_kept;
    wr && hit_pcs && cfg_be_i[1] && !cfg_wdata_i[15] && st.wake_event_flag
      |=> st.wake_event_flag;
  endproperty
  a_flag_kept: assert property (p_flag_kept) else $error("flag dropped");

endmodule : scpm_regs

// File: sim/scpm_host_model.sv
// Host bridge model issuing one configuration cycle at a time.
// Assumes the one-cycle request and ack timing of the register block.
`timescale 1ns/1ps
module scpm_host_model
(
  // Clock and answer
  input  wire logic        mclk_i,
  input  wire logic [31:0] cfg_rdata_i,
  input  wire logic        cfg_ack_i,
  // Request
  output logic             cfg_valid_o,
  output logic             cfg_write_o,
  output logic      [7:0]  cfg_addr_o,
  output logic      [3:0]  cfg_be_o,
  output logic      [31:0] cfg_wdata_o
);
  initial
  begin
    cfg_valid_o = 1'b0;
    cfg_write_o = 1'b0;
    cfg_addr_o  = 8'h00;
    cfg_be_o    = 4'h0;
    cfg_wdata_o = 32'h00000000;
  end

  // Request lasts one cycle; address, lanes and data stand until the ack edge,
  // then are scrambled so that no stale value can help a later request
  task xfer(input logic wr, input logic [7:0] a, input logic [3:0] be,
            input logic [31:0] d, output logic [31:0] q, output logic ok);
    int i;
    @(posedge mclk_i);
    cfg_valid_o <= 1'b1;
    cfg_write_o <= wr;
    cfg_addr_o  <= a;
    cfg_be_o    <= be;
    cfg_wdata_o <= d;
    @(posedge mclk_i);
    cfg_valid_o <= 1'b0;
    q  = 32'hdeadbeef;
    ok = 1'b0;
    for (i = 0; i < 4; i++)
    begin
      @(posedge mclk_i);
      if (cfg_ack_i === 1'b1)
      begin
        q  = cfg_rdata_i;
        ok = 1'b1;
        break;
      end
    end
    cfg_addr_o  <= ~a;
    cfg_be_o    <= ~be;
    cfg_wdata_o <= ~d;
    #1;
  endtask : xfer
endmodule : scpm_host_model

// File: sim/scpm_regs_test.sv
// Self-checking bench for the power-management configuration registers.
// Assumes the host model for configuration cycles; pins driven here.
`timescale 1ns/1ps
module scpm_regs_test;
  logic        mclk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        cfg_valid, cfg_write, cfg_ack, wake_event_i = 1'b0, func_irq_i = 1'b0;
  logic [7:0]  cfg_addr, reported_irq_pin_o;
  logic [3:0]  cfg_be, irq_override_pins_i = 4'h0, irq_line_o;
  logic [31:0] cfg_wdata, cfg_rdata, q;
  logic        ack_ok;
  logic        pme_o, cold_wake_capable_flag_o, func_reset_o;
  logic [2:0]  standby_current_o;
  logic [1:0]  power_level_field_o;
  int          miscompares = 0;
  int          checks_done = 0;
  int          n;
  // Write address, lanes, data, read address, expected read value
  logic [31:0] rows [10][5] = '{
    '{32'h48, 32'hf, 32'hffffffff, 32'h48, 32'h00000103},
    '{32'h48, 32'h1, 32'h00000002, 32'h48, 32'h00000102},
    '{32'h48, 32'h1, 32'h00000001, 32'h48, 32'h00000101},
    '{32'h4c, 32'hf, 32'hffffffff, 32'h4c, 32'h00000070},
    '{32'h50, 32'hf, 32'h12345678, 32'h50, 32'h12345678},
    '{32'h50, 32'hf, 32'h12345678, 32'h2c, 32'h12345678},
    '{32'h50, 32'h3, 32'haaaa5555, 32'h2c, 32'h12345555},
    '{32'h2c, 32'hf, 32'hffffffff, 32'h2e, 32'h12345555},
    '{32'h40, 32'hf, 32'hffffffff, 32'h40, 32'h00000000},
    '{32'h4c, 32'h1, 32'h00000020, 32'h4c, 32'h00000020}};

  always #20 mclk_i = ~mclk_i;

  scpm_host_model scpm_host_model_i (.mclk_i(mclk_i), .cfg_rdata_i(cfg_rdata),
    .cfg_ack_i(cfg_ack), .cfg_valid_o(cfg_valid), .cfg_write_o(cfg_write),
    .cfg_addr_o(cfg_addr), .cfg_be_o(cfg_be), .cfg_wdata_o(cfg_wdata));

  scpm_regs #(.RESET_CYCLES(2)) scpm_regs_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .cfg_valid_i(cfg_valid), .cfg_write_i(cfg_write), .cfg_addr_i(cfg_addr),
    .cfg_be_i(cfg_be), .cfg_wdata_i(cfg_wdata), .cfg_rdata_o(cfg_rdata),
    .cfg_ack_o(cfg_ack), .wake_event_i(wake_event_i), .func_irq_i(func_irq_i),
    .irq_override_pins_i(irq_override_pins_i), .pme_o(pme_o), .irq_line_o(irq_line_o),
    .reported_irq_pin_o(reported_irq_pin_o),
    .cold_wake_capable_flag_o(cold_wake_capable_flag_o),
    .standby_current_o(standby_current_o), .power_level_field_o(power_level_field_o),
    .func_reset_o(func_reset_o));

  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    scpm_host_model_i.xfer(1'b1, a, be, d, q, ack_ok);
    chk(32'(ack_ok), 32'h1);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp);
    scpm_host_model_i.xfer(1'b0, a, 4'hf, 32'h0, q, ack_ok);
    chk(32'(ack_ok), 32'h1);
    chk(q, exp);
  endtask : rd

  // Pins change on an edge; two edges let the registered outputs settle
  task pins(input logic irq, input logic [3:0] ovr);
    @(posedge mclk_i);
    func_irq_i          <= irq;
    irq_override_pins_i <= ovr;
    repeat (2) @(posedge mclk_i);
    #1;
  endtask : pins

  task do_reset();
    @(posedge mclk_i);
    reset_n_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    #1;
  endtask : do_reset

  task tally_and_finish();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    miscompares++;
    tally_and_finish();
  end

  initial
  begin
    do_reset();
    chk(32'(reported_irq_pin_o), 32'h1);
    rd(8'h48, 32'h0);
    rd(8'h4c, 32'h0);
    rd(8'h50, 32'h0);
    $display("test reset values done");
    for (int r = 0; r < 10; r++)
    begin
      wr(rows[r][0][7:0], rows[r][1][3:0], rows[r][2]);
      rd(rows[r][3][7:0], rows[r][4]);
    end
    $display("test register rows done");
    pins(1'b1, 4'h0);
    chk(32'(irq_line_o), 32'h2);
    chk(32'(reported_irq_pin_o), 32'h2);
    pins(1'b1, 4'h4);
    chk(32'(irq_line_o), 32'h4);
    chk(32'(reported_irq_pin_o), 32'h3);
    pins(1'b1, 4'h0);
    wr(8'h4c, 4'h1, 32'h10);
    pins(1'b1, 4'h0);
    chk({cold_wake_capable_flag_o, standby_current_o, irq_line_o}, 32'h91);
    wr(8'h4c, 4'h1, 32'h00);
    pins(1'b0, 4'h0);
    chk({cold_wake_capable_flag_o, standby_current_o, irq_line_o}, 32'h00);
    $display("test interrupt and capability done");
    @(posedge mclk_i);
    wake_event_i <= 1'b1;
    @(posedge mclk_i);
    wake_event_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
    chk(32'(pme_o), 32'h1);
    rd(8'h48, 32'h00008101);
    wr(8'h48, 4'h2, 32'h0);
    pins(1'b0, 4'h0);
    chk(32'(pme_o), 32'h0);
    rd(8'h48, 32'h00008001);
    wr(8'h48, 4'h2, 32'h8100);
    pins(1'b0, 4'h0);
    chk(32'(pme_o), 32'h0);
    rd(8'h48, 32'h00000101);
    $display("test wake flag done");
    // Event and write-one-clear in the same cycle: the event must win
    fork
      wr(8'h48, 4'h2, 32'h8100);
      begin
        @(posedge mclk_i);
        wake_event_i <= 1'b1;
        @(posedge mclk_i);
        wake_event_i <= 1'b0;
      end
    join
    rd(8'h48, 32'h00008101);
    wr(8'h48, 4'h2, 32'h8100);
    $display("test set against clear done");
    wr(8'h48, 4'h1, 32'h3);
    chk(32'(power_level_field_o), 32'h3);
    chk(32'(func_reset_o), 32'h0);
    wr(8'h48, 4'h1, 32'h0);
    n = 0;
    repeat (8)
    begin
      n += int'(func_reset_o === 1'b1);
      @(posedge mclk_i);
      #1;
    end
    chk(32'(n), 32'h2);
    rd(8'h48, 32'h00000100);
    $display("test function reset done");
    wr(8'h4c, 4'h1, 32'h70);
    do_reset();
    rd(8'h48, 32'h0);
    rd(8'h4c, 32'h0);
    chk(32'(reported_irq_pin_o), 32'h1);
    $display("test global reset done");
    tally_and_finish();
  end
endmodule : scpm_regs_test
